// ---- vec_ctrl_regs.sv ----
// Control and status register bank of the video encoder with pixel input capture
// Contract
// RULE_01: Identity register returns fixed code
// RULE_02: Revision register read-only, ignores writes
// RULE_03: Status shows separate and composite connection
// RULE_04: Even caption flag set, cleared after rewrites
// RULE_05: Odd caption flag set, cleared after rewrites
// RULE_06: Field sequence uses two bits at 60Hz
// RULE_07: Format bit seven selects colour bars
// RULE_08: Luma format bit: twos complement or binary
// RULE_09: Chroma format bit: twos complement or binary
// RULE_10: Interlaced scan sampling per format code
// RULE_11: Progressive scan sampling, both edges single port
// RULE_12: Subcarrier phase offset in 256 steps
// RULE_13: Nine-bit Cb gain across two registers
// RULE_14: Nine-bit Cr gain across two registers
// RULE_15: Nine-bit luma gain across two registers
// RULE_16: Black level from low seven bits
// RULE_17: Blanking level from low seven bits
// RULE_18: Cross colour reduction on composite only
// RULE_19: Chroma delay in half pixel steps
// RULE_20: Mode bits power down converters
// RULE_21: Mode bit five inverts alternating switch
// RULE_22: Mode bit two sets chroma bandwidth
// RULE_23: Mode bit one enables alternating-line encoding
// RULE_24: Mode bit zero selects field rate
// RULE_25: Reset loads defaults, status flags cleared
//
// Our own choice: the APB register port.
`include "vec_regs.svh"

module vec_ctrl_regs #(
   parameter logic [7:0] DEVICE_CODE = 8'h5a, // Arbitrary
   parameter logic [7:0] REVISION_CODE = 8'h03, // Arbitrary
   parameter int HALF_PIXEL_CYC = `VEC_HALF_PIXEL_CYC
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Video source pins
   input wire logic pixel_line_clock,
   input wire logic clock_qualifier,
   input wire logic [7:0] video_port_a,
   input wire logic [7:0] video_port_b,
   // Connection sense pins
   input wire logic separate_video_connected,
   input wire logic composite_connected,
   // Encoder core events and state
   input wire logic scan_mode_select,
   input wire logic even_caption_encoded,
   input wire logic odd_caption_encoded,
   input wire logic [1:0] even_data_written,
   input wire logic [1:0] odd_data_written,
   input wire logic [2:0] field_sequence_index,
   // Captured pixels
   output logic [7:0] luma_out,
   output logic [7:0] chroma_out,
   output logic [7:0] separate_chroma_out,
   output logic sample_valid,
   output logic format_reserved,
   // Encoder settings
   output logic [7:0] subcarrier_phase_value,
   output logic [8:0] cb_gain_value,
   output logic [8:0] cr_gain_value,
   output logic [8:0] luma_gain_value,
   output logic [6:0] black_level,
   output logic [6:0] blanking_level,
   output logic crosscolor_reduce_enable,
   output logic separate_video_power_down,
   output logic composite_power_down,
   output logic pal_switch_inverted,
   output logic chroma_standard_bw,
   output logic pal_encode_enable,
   output logic field_rate_60
);
   vec_pkg::vec_state_s st_r;
   vec_pkg::vec_state_s st_nxt;
   logic [19:0] pins_s;
   logic pxc_s;
   logic qual_s;
   logic [7:0] port_a_s;
   logic [7:0] port_b_s;
   logic svid_s;
   logic cvid_s;
   logic [7:0] idx;
   logic wr_en;
   logic setup;
   logic [7:0] status;
   logic [1:0] code_lo;
   logic rise;
   logic fall;
   logic take;
   logic [7:0] raw_y;
   logic [7:0] raw_c;
   logic [7:0] pix;

   // ==========================================================
   // Pin synchronisers
   vec_sync #(
      .W(20)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .d({pixel_line_clock, clock_qualifier, video_port_a, video_port_b,
         separate_video_connected, composite_connected}),
      .q(pins_s)
   );

   assign {pxc_s, qual_s, port_a_s, port_b_s, svid_s, cvid_s} = pins_s;

   // ==========================================================
   // Bus decode; pready low while frozen so no write is lost
   assign idx = paddr[9:`VEC_ADDR_LSB];
   assign setup = psel && !penable && ce;
   assign wr_en = psel && penable && pwrite && ce;
   assign pready = ce;
   assign prdata = {24'h000000, st_r.rdata};
   assign pslverr = psel && penable && st_r.err;

   assign status = {1'b0, svid_s, cvid_s, st_r.even_done, st_r.odd_done, // RULE_03
      field_sequence_index[2] & ~st_r.mode[`VEC_MODE_RATE_60], // RULE_06
      field_sequence_index[1:0]};

   // ==========================================================
   // Pixel capture decode
   assign code_lo = st_r.fmt[1:0];
   assign rise = pxc_s && !st_r.pxc_d;
   assign fall = !pxc_s && st_r.pxc_d;
   assign pix = st_r.fmt[`VEC_FMT_CODE_TOP] ? port_b_s : port_a_s;

   always_comb begin
      format_reserved = 1'b0;
      take = 1'b0;
      raw_y = port_a_s;
      raw_c = port_b_s;
      case (code_lo)
         `VEC_FCD_DUAL_PORT: begin
            take = scan_mode_select ? rise : rise && qual_s; // RULE_10 RULE_11
         end
         `VEC_FCD_SINGLE_422: begin
            take = scan_mode_select ? rise || fall : rise; // RULE_10 RULE_11
            raw_y = pix;
            raw_c = pix;
         end
         `VEC_FCD_SINGLE_656: begin
            format_reserved = scan_mode_select; // RULE_11
            take = !scan_mode_select && rise; // RULE_10
            raw_y = pix;
            raw_c = pix;
         end
         default: begin
            format_reserved = 1'b1; // RULE_10 RULE_11
         end
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      if (ce) begin
         st_nxt.pxc_d = pxc_s;
         // Write effects; identity, revision and status ignore writes
         if (wr_en) begin
            case (idx)
               `VEC_IDX_FORMAT: st_nxt.fmt = pwdata[7:0]; // RULE_07
               `VEC_IDX_PHASE: st_nxt.phase = pwdata[7:0]; // RULE_12
               `VEC_IDX_CB_GAIN: st_nxt.cb_lo = pwdata[7:0]; // RULE_13
               `VEC_IDX_CR_GAIN: st_nxt.cr_lo = pwdata[7:0]; // RULE_14
               `VEC_IDX_BLACK: st_nxt.black = pwdata[7:0]; // RULE_16
               `VEC_IDX_BLANKING: st_nxt.blank = pwdata[7:0]; // RULE_17
               `VEC_IDX_Y_GAIN: st_nxt.y_lo = pwdata[7:0]; // RULE_15
               `VEC_IDX_XCOLOR: st_nxt.xcol = pwdata[7:0]; // RULE_18
               `VEC_IDX_MODE: st_nxt.mode = pwdata[7:0]; // RULE_20
               default: st_nxt.fmt = st_r.fmt;
            endcase
         end
         // Read data captured in setup so prdata comes from a register
         if (setup) begin
            st_nxt.err = 1'b0;
            case (idx)
               `VEC_IDX_IDENTITY: st_nxt.rdata = DEVICE_CODE; // RULE_01
               `VEC_IDX_REVISION: st_nxt.rdata = REVISION_CODE; // RULE_02
               `VEC_IDX_STATUS: st_nxt.rdata = status; // RULE_03
               `VEC_IDX_FORMAT: st_nxt.rdata = st_r.fmt;
               `VEC_IDX_PHASE: st_nxt.rdata = st_r.phase;
               `VEC_IDX_CB_GAIN: st_nxt.rdata = st_r.cb_lo;
               `VEC_IDX_CR_GAIN: st_nxt.rdata = st_r.cr_lo;
               `VEC_IDX_BLACK: st_nxt.rdata = st_r.black;
               `VEC_IDX_BLANKING: st_nxt.rdata = st_r.blank;
               `VEC_IDX_Y_GAIN: st_nxt.rdata = st_r.y_lo;
               `VEC_IDX_XCOLOR: st_nxt.rdata = st_r.xcol;
               `VEC_IDX_MODE: st_nxt.rdata = st_r.mode;
               default: begin
                  st_nxt.rdata = 8'h00;
                  st_nxt.err = 1'b1;
               end
            endcase
         end
         // Caption flags: both bytes must be rewritten; a set in the same cycle wins
         st_nxt.even_wr = st_r.even_wr | even_data_written;
         if (&st_nxt.even_wr) begin
            st_nxt.even_done = 1'b0; // RULE_04
            st_nxt.even_wr = 2'b00;
         end
         if (even_caption_encoded) begin
            st_nxt.even_done = 1'b1; // RULE_04
         end
         st_nxt.odd_wr = st_r.odd_wr | odd_data_written;
         if (&st_nxt.odd_wr) begin
            st_nxt.odd_done = 1'b0; // RULE_05
            st_nxt.odd_wr = 2'b00;
         end
         if (odd_caption_encoded) begin
            st_nxt.odd_done = 1'b1; // RULE_05
         end
         // Sample capture; single-port streams alternate chroma then luma
         st_nxt.valid = take;
         if (take) begin
            st_nxt.half = (code_lo == `VEC_FCD_DUAL_PORT) ? 1'b0 : !st_r.half;
            if (st_r.bar_cnt == `VEC_BAR_WIDTH) begin
               st_nxt.bar_cnt = 8'h00;
               st_nxt.bar_idx = st_r.bar_idx + 3'd1;
            end else begin
               st_nxt.bar_cnt = st_r.bar_cnt + 8'd1;
            end
            if (st_r.fmt[`VEC_FMT_BAR]) begin
               st_nxt.luma = `VEC_BAR_LUMA_TOP - 8'(st_r.bar_idx * `VEC_BAR_LUMA_STEP); // RULE_07
               st_nxt.chroma = `VEC_CHROMA_MID; // RULE_07
            end else begin
               // Held as offset binary inside; twos complement gets its sign flipped
               if (code_lo == `VEC_FCD_DUAL_PORT || st_r.half) begin
                  st_nxt.luma = {raw_y[7] ^ ~st_r.fmt[`VEC_FMT_LUMA_FMT], raw_y[6:0]}; // RULE_08
               end
               if (code_lo == `VEC_FCD_DUAL_PORT || !st_r.half) begin
                  st_nxt.chroma = {raw_c[7] ^ ~st_r.fmt[`VEC_FMT_CHROMA_FMT], // RULE_09
                     raw_c[6:0]};
               end
            end
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0; // RULE_25
         st_r.fmt <= `VEC_RST_FORMAT; // RULE_25
         st_r.phase <= `VEC_RST_PHASE;
         st_r.cb_lo <= `VEC_RST_CB_GAIN;
         st_r.cr_lo <= `VEC_RST_CR_GAIN;
         st_r.black <= `VEC_RST_BLACK;
         st_r.blank <= `VEC_RST_BLANKING;
         st_r.y_lo <= `VEC_RST_Y_GAIN;
         st_r.xcol <= `VEC_RST_XCOLOR;
         st_r.mode <= `VEC_RST_MODE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Separate-video chroma delay; composite chroma is never delayed
   vec_chroma_delay #(
      .W(8),
      .HALF(HALF_PIXEL_CYC)
   ) u_delay (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .code(st_r.xcol[2:0]), // RULE_19
      .din(st_r.chroma),
      .dout(separate_chroma_out)
   );

   // ==========================================================
   // Outputs
   assign luma_out = st_r.luma;
   assign chroma_out = st_r.chroma;
   assign sample_valid = st_r.valid;
   assign subcarrier_phase_value = st_r.phase; // RULE_12
   assign cb_gain_value = {st_r.black[`VEC_GAIN_MSB], st_r.cb_lo}; // RULE_13
   assign cr_gain_value = {st_r.blank[`VEC_GAIN_MSB], st_r.cr_lo}; // RULE_14
   assign luma_gain_value = {st_r.xcol[`VEC_XR_Y_MSB], st_r.y_lo}; // RULE_15
   assign black_level = st_r.black[6:0]; // RULE_16
   assign blanking_level = st_r.blank[6:0]; // RULE_17
   assign crosscolor_reduce_enable = st_r.xcol[`VEC_XR_ENABLE]; // RULE_18
   assign separate_video_power_down = st_r.mode[`VEC_MODE_SDOWN]; // RULE_20
   assign composite_power_down = st_r.mode[`VEC_MODE_CDOWN]; // RULE_20
   assign pal_switch_inverted = st_r.mode[`VEC_MODE_PAL_PHASE]; // RULE_21
   assign chroma_standard_bw = st_r.mode[`VEC_MODE_CHROMA_BW]; // RULE_22
   assign pal_encode_enable = st_r.mode[`VEC_MODE_PAL_EN]; // RULE_23
   assign field_rate_60 = st_r.mode[`VEC_MODE_RATE_60]; // RULE_24

   // ==========================================================
   // Checks
   default clocking cb_main @(posedge clk); endclocking
   default disable iff (rst);

   property p_identity;
      psel && !penable && !pwrite && ce && idx == `VEC_IDX_IDENTITY ##1 penable
         |-> prdata[7:0] == DEVICE_CODE;
   endproperty
   a_identity: assert property (p_identity) else $error("identity read wrong"); // RULE_01

   property p_revision;
      psel && !penable && !pwrite && ce && idx == `VEC_IDX_REVISION ##1 penable
         |-> prdata == {24'h000000, REVISION_CODE};
   endproperty
   a_revision: assert property (p_revision) else $error("revision read wrong"); // RULE_02

   property p_connect;
      setup && !pwrite && idx == `VEC_IDX_STATUS
         |=> prdata[`VEC_STS_SVIDEO] == $past(svid_s)
         && prdata[`VEC_STS_COMPOSITE] == $past(cvid_s);
   endproperty
   a_connect: assert property (p_connect) else $error("connection status wrong"); // RULE_03

   property p_even_set;
      ce && even_caption_encoded |=> st_r.even_done;
   endproperty
   a_even_set: assert property (p_even_set) else $error("even caption flag not set"); // RULE_04

   property p_odd_rise;
      $rose(st_r.odd_done) |-> $past(odd_caption_encoded);
   endproperty
   a_odd_rise: assert property (p_odd_rise) else $error("odd flag set without cause"); // RULE_05

   property p_seq_60;
      setup && !pwrite && idx == `VEC_IDX_STATUS && field_rate_60
         |=> !prdata[`VEC_STS_SEQ_TOP];
   endproperty
   a_seq_60: assert property (p_seq_60) else $error("field sequence top bit at 60Hz"); // RULE_06

   property p_cb_gain;
      wr_en && idx == `VEC_IDX_CB_GAIN |=> cb_gain_value[7:0] == $past(pwdata[7:0]);
   endproperty
   a_cb_gain: assert property (p_cb_gain) else $error("cb gain not written"); // RULE_13

   property p_power;
      wr_en && idx == `VEC_IDX_MODE
         |=> separate_video_power_down == $past(pwdata[`VEC_MODE_SDOWN])
         && composite_power_down == $past(pwdata[`VEC_MODE_CDOWN]);
   endproperty
   a_power: assert property (p_power) else $error("power down bits wrong"); // RULE_20
endmodule

// ---- vec_regs.svh ----
// Register indices, field positions, reset values and timing for the encoder control bank
`ifndef VEC_REGS_SVH
`define VEC_REGS_SVH

// ==========================================================
// Register indices (byte address is index times four)
`define VEC_ADDR_LSB 2
`define VEC_IDX_IDENTITY 8'h00
`define VEC_IDX_REVISION 8'h01
`define VEC_IDX_STATUS 8'h02
`define VEC_IDX_FORMAT 8'h3a
`define VEC_IDX_PHASE 8'h5a
`define VEC_IDX_CB_GAIN 8'h5b
`define VEC_IDX_CR_GAIN 8'h5c
`define VEC_IDX_BLACK 8'h5d
`define VEC_IDX_BLANKING 8'h5e
`define VEC_IDX_Y_GAIN 8'h5f
`define VEC_IDX_XCOLOR 8'h60
`define VEC_IDX_MODE 8'h61

// ==========================================================
// Reset values
`define VEC_RST_FORMAT 8'h8d
`define VEC_RST_PHASE 8'h00
`define VEC_RST_CB_GAIN 8'h01
`define VEC_RST_CR_GAIN 8'h6b
`define VEC_RST_BLACK 8'hcc
`define VEC_RST_BLANKING 8'hb8
`define VEC_RST_Y_GAIN 8'h2e
`define VEC_RST_XCOLOR 8'h20
`define VEC_RST_MODE 8'h05

// ==========================================================
// Field positions
`define VEC_STS_SVIDEO 6
`define VEC_STS_COMPOSITE 5
`define VEC_STS_EVEN_CC 4
`define VEC_STS_ODD_CC 3
`define VEC_STS_SEQ_TOP 2
`define VEC_FMT_BAR 7
`define VEC_FMT_CODE_TOP 4
`define VEC_FMT_LUMA_FMT 3
`define VEC_FMT_CHROMA_FMT 2
`define VEC_GAIN_MSB 7
`define VEC_XR_ENABLE 6
`define VEC_XR_Y_MSB 5
`define VEC_MODE_SDOWN 7
`define VEC_MODE_CDOWN 6
`define VEC_MODE_PAL_PHASE 5
`define VEC_MODE_CHROMA_BW 2
`define VEC_MODE_PAL_EN 1
`define VEC_MODE_RATE_60 0

// ==========================================================
// Format codes (low two bits) and timing
`define VEC_FCD_RESERVED 2'b00
`define VEC_FCD_DUAL_PORT 2'b01
`define VEC_FCD_SINGLE_422 2'b10
`define VEC_FCD_SINGLE_656 2'b11
`define VEC_CLK_PERIOD_NS 10
`define VEC_HALF_PIXEL_NS 40
`define VEC_HALF_PIXEL_CYC (`VEC_HALF_PIXEL_NS / `VEC_CLK_PERIOD_NS)
`define VEC_BAR_WIDTH 8'd90
`define VEC_BAR_LUMA_TOP 8'heb
`define VEC_BAR_LUMA_STEP 8'd24
`define VEC_CHROMA_MID 8'h80

`endif

// ---- vec_pkg.sv ----
// Types shared by the encoder control bank
package vec_pkg;

   // ==========================================================
   // Register and pixel path state of the top module
   typedef struct packed {
      logic [7:0] fmt;
      logic [7:0] phase;
      logic [7:0] cb_lo;
      logic [7:0] cr_lo;
      logic [7:0] black;
      logic [7:0] blank;
      logic [7:0] y_lo;
      logic [7:0] xcol;
      logic [7:0] mode;
      logic even_done;
      logic odd_done;
      logic [1:0] even_wr;
      logic [1:0] odd_wr;
      logic [7:0] rdata;
      logic err;
      logic pxc_d;
      logic half;
      logic [7:0] luma;
      logic [7:0] chroma;
      logic valid;
      logic [2:0] bar_idx;
      logic [7:0] bar_cnt;
   } vec_state_s;

endpackage

// ---- vec_sync.sv ----
// Two-flop synchroniser for inputs from outside the clock domain
module vec_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } vec_sync_s;

   vec_sync_s st_r;
   vec_sync_s st_nxt;

   // ==========================================================
   // First stage feeds only the second
   always_comb begin
      st_nxt = st_r;
      if (ce) begin
         st_nxt.s1 = d;
         st_nxt.s2 = st_r.s1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule

// ---- vec_chroma_delay.sv ----
// Selectable chroma delay line in half pixel clock steps
module vec_chroma_delay #(
   parameter int W = 8,
   parameter int HALF = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Control and data
   input wire logic [2:0] code,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   localparam int DEPTH = 4 * HALF;

   typedef struct packed {
      logic [DEPTH*W-1:0] sr;
      logic [W-1:0] q;
   } vec_delay_s;

   vec_delay_s st_r;
   vec_delay_s st_nxt;
   int taps;

   // ==========================================================
   // Tap chosen in whole system cycles; one output register on every tap
   always_comb begin
      st_nxt = st_r;
      taps = code[2] ? DEPTH : int'(code[1:0]) * HALF;
      if (ce) begin
         st_nxt.sr = {st_r.sr[DEPTH*W-W-1:0], din};
         if (taps == 0) begin
            st_nxt.q = din;
         end else begin
            st_nxt.q = st_r.sr[taps*W-1 -: W];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dout = st_r.q;
endmodule

// ---- vec_src_model.sv ----
// Upstream pixel source model driving the video ports of the encoder
module vec_src_model (
   // Control from the bench
   input wire logic run,
   input wire logic [7:0] a_val,
   input wire logic [7:0] b_val,
   // Video pins
   output logic pixel_line_clock,
   output logic [7:0] video_port_a,
   output logic [7:0] video_port_b
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // Pixel clock, 80 ns period while a frame runs
   // It stands low between frames so the block never sees stray edges
   initial pixel_line_clock = 1'b0;
   always begin
      #40;
      pixel_line_clock = run ? ~pixel_line_clock : 1'b0;
   end

   // ==========================================================
   // Port data, held through the frame
   // Idle ports show the inverse so stale data never passes for a sample
   assign video_port_a = run ? a_val : ~a_val;
   assign video_port_b = run ? b_val : ~b_val;
endmodule

// ---- vec_ctrl_regs_tb.sv ----
// Self-checking bench for the encoder control register bank
module vec_ctrl_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // Signals
   localparam logic [7:0] DEV_CODE = 8'h3c; // Arbitrary value
   localparam logic [7:0] REV_CODE = 8'h07; // Arbitrary value
   logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, run;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pixel_line_clock, clock_qualifier, separate_video_connected, composite_connected;
   logic scan_mode_select, even_caption_encoded, odd_caption_encoded, sample_valid;
   logic [1:0] even_data_written, odd_data_written;
   logic [2:0] field_sequence_index;
   logic [7:0] video_port_a, video_port_b, a_val, b_val, luma_out, chroma_out;
   logic [7:0] subcarrier_phase_value, separate_chroma_out;
   logic format_reserved, crosscolor_reduce_enable, separate_video_power_down;
   logic composite_power_down, pal_switch_inverted, chroma_standard_bw;
   logic pal_encode_enable, field_rate_60, err;
   logic [8:0] cb_gain_value, cr_gain_value, luma_gain_value;
   logic [6:0] black_level, blanking_level;
   int n_mismatch, n_checks;
   logic [7:0] rw_idx [9] = '{8'h3a, 8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h61};
   logic [7:0] rw_def [9] = '{8'h8d, 8'h00, 8'h01, 8'h6b, 8'hcc, 8'hb8, 8'h2e, 8'h20, 8'h05};

   vec_ctrl_regs #(.DEVICE_CODE(DEV_CODE), .REVISION_CODE(REV_CODE), .HALF_PIXEL_CYC(1))
      vec_ctrl_regs_inst (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .pixel_line_clock, .clock_qualifier, .video_port_a,
      .video_port_b, .separate_video_connected, .composite_connected, .scan_mode_select,
      .even_caption_encoded, .odd_caption_encoded, .even_data_written, .odd_data_written,
      .field_sequence_index, .luma_out, .chroma_out, .separate_chroma_out, .sample_valid,
      .format_reserved, .subcarrier_phase_value, .cb_gain_value, .cr_gain_value,
      .luma_gain_value, .black_level, .blanking_level, .crosscolor_reduce_enable,
      .separate_video_power_down, .composite_power_down, .pal_switch_inverted,
      .chroma_standard_bw, .pal_encode_enable, .field_rate_60);

   vec_src_model vec_src_model_inst (.run, .a_val, .b_val, .pixel_line_clock,
      .video_port_a, .video_port_b);

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Request held until pready is seen high; data and error taken at that edge
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_mismatch++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
      apb(1'b0, idx, 8'h00);
      chk(rd, {24'h0, exp}, what);
   endtask

   // One-cycle pulses on the caption event inputs
   task automatic ev(input logic e, input logic o, input logic [1:0] ew, input logic [1:0] ow);
      @(posedge clk);
      even_caption_encoded <= e;
      odd_caption_encoded <= o;
      even_data_written <= ew;
      odd_data_written <= ow;
      @(posedge clk);
      even_caption_encoded <= 1'b0;
      odd_caption_encoded <= 1'b0;
      even_data_written <= 2'b00;
      odd_data_written <= 2'b00;
   endtask

   // Frame of 80 cycles: counts samples, checks the last one
   task automatic frame(input int lo, input int hi, input logic dc, input logic [7:0] ey,
                        input logic [7:0] ec);
      int n;
      n = 0;
      @(posedge clk);
      run <= 1'b1;
      repeat (80) begin
         @(posedge clk);
         if (sample_valid === 1'b1) n++;
      end
      chk((n >= lo && n <= hi), 1'b1, "sample count");
      if (dc) chk({luma_out, chroma_out, separate_chroma_out}, {ey, ec, ec}, "pixel");
      run <= 1'b0;
      repeat (12) @(posedge clk);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      for (int i = 0; i < 9; i++) rd_chk(rw_idx[i], rw_def[i], "default");
      rd_chk(8'h00, DEV_CODE, "identity");
      rd_chk(8'h01, REV_CODE, "revision");
      chk({cb_gain_value, cr_gain_value, luma_gain_value}, {9'h101, 9'h16b, 9'h12e},
          "gain rst");
      chk({crosscolor_reduce_enable, chroma_standard_bw, pal_encode_enable, field_rate_60},
          4'b0101, "mode rst");
      $display("test reset done");
   endtask

   task automatic t_ro;
      apb(1'b1, 8'h00, 8'hff);
      apb(1'b1, 8'h01, 8'hff);
      rd_chk(8'h00, DEV_CODE, "identity wr");
      rd_chk(8'h01, REV_CODE, "revision wr");
      apb(1'b1, 8'h10, 8'h55);
      chk(err, 1'b1, "unmapped wr err");
      rd_chk(8'h10, 8'h00, "unmapped rd");
      chk(err, 1'b1, "unmapped rd err");
      $display("test ro done");
   endtask

   task automatic t_regs;
      apb(1'b1, 8'h5b, 8'h15);
      apb(1'b1, 8'h5d, 8'hbc);
      apb(1'b1, 8'h5c, 8'h8c);
      apb(1'b1, 8'h5e, 8'hbc);
      apb(1'b1, 8'h5f, 8'h45);
      apb(1'b1, 8'h60, 8'h60);
      apb(1'b1, 8'h5a, 8'ha5);
      apb(1'b1, 8'h61, 8'he6);
      @(negedge clk);
      chk({cb_gain_value, black_level}, {9'h115, 7'h3c}, "cb black");
      chk({cr_gain_value, blanking_level}, {9'h18c, 7'h3c}, "cr blank");
      chk({luma_gain_value, crosscolor_reduce_enable}, {9'h145, 1'b1}, "y xc");
      chk(subcarrier_phase_value, 8'ha5, "phase");
      chk({separate_video_power_down, composite_power_down, pal_switch_inverted,
           chroma_standard_bw, pal_encode_enable, field_rate_60}, 6'b111110,
           "mode");
      rd_chk(8'h61, 8'he6, "mode rd");
      $display("test regs done");
   endtask

   task automatic t_status;
      separate_video_connected <= 1'b1;
      field_sequence_index <= 3'b101;
      @(posedge clk);
      rd_chk(8'h02, 8'h45, "status 50hz");
      separate_video_connected <= 1'b0;
      composite_connected <= 1'b1;
      apb(1'b1, 8'h61, 8'h05);
      rd_chk(8'h02, 8'h21, "status 60hz");
      ev(1'b1, 1'b0, 2'b00, 2'b00);
      rd_chk(8'h02, 8'h31, "even set");
      ev(1'b0, 1'b0, 2'b01, 2'b00);
      rd_chk(8'h02, 8'h31, "even one byte");
      ev(1'b0, 1'b1, 2'b10, 2'b00);
      rd_chk(8'h02, 8'h29, "even clr odd set");
      ev(1'b0, 1'b0, 2'b00, 2'b11);
      rd_chk(8'h02, 8'h21, "odd clr");
      $display("test status done");
   endtask

   task automatic t_pixel;
      apb(1'b1, 8'h3a, 8'h0d);
      frame(8, 11, 1'b1, 8'h37, 8'hc4);
      apb(1'b1, 8'h3a, 8'h05);
      frame(8, 11, 1'b1, 8'hb7, 8'hc4);
      apb(1'b1, 8'h3a, 8'h09);
      frame(8, 11, 1'b1, 8'h37, 8'h44);
      clock_qualifier <= 1'b0;
      frame(0, 0, 1'b0, 8'h00, 8'h00);
      clock_qualifier <= 1'b1;
      apb(1'b1, 8'h3a, 8'h8d);
      frame(8, 11, 1'b1, 8'heb, 8'h80);
      apb(1'b1, 8'h3a, 8'h0c);
      frame(0, 0, 1'b0, 8'h00, 8'h00);
      chk(format_reserved, 1'b1, "reserved 0");
      scan_mode_select <= 1'b1;
      apb(1'b1, 8'h3a, 8'h0e);
      frame(17, 21, 1'b1, 8'h37, 8'h37);
      apb(1'b1, 8'h3a, 8'h0d);
      frame(8, 11, 1'b0, 8'h00, 8'h00);
      apb(1'b1, 8'h3a, 8'h0f);
      @(negedge clk);
      chk(format_reserved, 1'b1, "reserved 1");
      $display("test pixel done");
   endtask

   // ==========================================================
   // Clock and main sequence
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      {psel, penable, pwrite, run, scan_mode_select} = '0;
      {even_caption_encoded, odd_caption_encoded, even_data_written, odd_data_written} = '0;
      {separate_video_connected, composite_connected, field_sequence_index} = '0;
      clock_qualifier = 1'b1;
      paddr = '0;
      pwdata = '0;
      a_val = 8'h37;
      b_val = 8'hc4;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_ro();
      t_regs();
      t_status();
      t_pixel();
      complete_run();
   end
endmodule
